/* pio_pkg.sv */
// Constants and selector codes for the parallel port control logic.
// Assumes one 8-pin port sampled on the instruction-cycle clock.
// How it works
// - Output data latch keeps the last written value until software rewrites it.
// - Input pins are not latched; a read samples live pin level.
// - A written output value reaches the pins in the following cycle.
// - An output-mode pin with alternate enable 0 is driven from its output data bit.
// - Reading the pin register returns live levels of input-mode pins.
// - Direction bit 0 means input, 1 means output.
// - Alternate enable 1 routes peripheral output; 0 uses the data latch.
// - Drive type picks push-pull or low-only open-drain.
// - Pull-up connects only for inputs or open-drain outputs.
// - Route field 01 or 11 puts second UART on bits 6 and 5.
// - Route field 00 or 10 puts SPI-style MISO, MOSI, clock, select on 6-3.
// - Route field 10 or 11 puts synchronous serial clock on bit 2.
package pio_pkg;

    localparam int PORT_W = 8;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] ALT_RST = 8'h00;
    localparam logic [7:0] DRIVE_RST = 8'h00;
    localparam logic [7:0] PULLUP_RST = 8'h00;
    localparam logic [1:0] ROUTE_RST = 2'h0;
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [7:0] READ_RST = 8'h00;
    // Routed peripheral inputs idle high while not selected.
    localparam logic [5:0] PERIPH_IN_IDLE = 6'h3F;

    // Bit positions of the routed serial signals on the port.
    localparam int BIT_MISO_RX = 6;
    localparam int BIT_MOSI_TX = 5;
    localparam int BIT_SPI_CLK = 4;
    localparam int BIT_SPI_SS = 3;
    localparam int BIT_SYNC_CLK = 2;

    // Route field bit that selects the UART, and the one that selects the sync clock.
    localparam int ROUTE_UART_BIT = 0;
    localparam int ROUTE_SYNC_BIT = 1;

    // Register selected by a software write.
    typedef enum logic [2:0]
    {
        SEL_DATA,
        SEL_DIR,
        SEL_ALT,
        SEL_DRIVE,
        SEL_PULLUP,
        SEL_ROUTE
    } reg_sel_e;

endpackage

/* parallel_io_port_control.sv */
// Parallel port control: output latch, direction, alternate output routing,
// drive type, pull-ups and serial-signal routing for one 8-pin port.
// Assumes the CPU issues one-cycle write and read strobes on clock_in and
// that pin levels are asynchronous to clock_in.
`timescale 1ns/1ns

module parallel_io_port_control
    import pio_pkg::*;
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_b_in,
    // CPU register access.
    input wire logic wr_en_in,
    input wire reg_sel_e wr_sel_in,
    input wire logic [7:0] wr_data_in,
    input wire logic rd_en_in,
    output logic [7:0] port_pin_read_out,
    output logic [7:0] port_direction_out,
    output logic [1:0] serial_route_field_out,
    // Pins.
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe_out,
    output logic [7:0] pullup_on_out,
    // Peripheral outputs toward the pins.
    input wire logic [7:0] periph_out_in,
    input wire logic uart_b_transmit_in,
    input wire logic spi_miso_in,
    input wire logic spi_mosi_in,
    input wire logic spi_style_clock_in,
    input wire logic sync_serial_clock_in,
    // Peripheral inputs taken from the pins.
    output logic uart_b_receive_out,
    output logic spi_miso_out,
    output logic spi_mosi_out,
    output logic spi_style_clock_out,
    output logic spi_ss_out,
    output logic sync_serial_clock_out
);

    // Control registers and their next values.
    logic [7:0] port_output_data_r;
    logic [7:0] port_output_data_nxt;
    logic [7:0] port_direction_r;
    logic [7:0] port_direction_nxt;
    logic [7:0] port_alt_output_enable_r;
    logic [7:0] port_alt_output_enable_nxt;
    logic [7:0] port_drive_type_r;
    logic [7:0] port_drive_type_nxt;
    logic [7:0] port_pullup_enable_r;
    logic [7:0] port_pullup_enable_nxt;
    logic [1:0] serial_route_field_r;
    logic [1:0] serial_route_field_nxt;

    // Pin synchroniser and read path.
    logic [7:0] pin_meta_r;
    logic [7:0] pin_sync_r;
    logic [7:0] read_r;
    logic [7:0] read_nxt;
    logic [5:0] periph_in_r;
    logic [5:0] periph_in_nxt;

    // Pin drive decode.
    logic [7:0] alt_src;
    logic [7:0] drive_val;

    // Software writes; an unselected register keeps its value indefinitely.
    always_comb
    begin
        port_output_data_nxt = port_output_data_r;
        port_direction_nxt = port_direction_r;
        port_alt_output_enable_nxt = port_alt_output_enable_r;
        port_drive_type_nxt = port_drive_type_r;
        port_pullup_enable_nxt = port_pullup_enable_r;
        serial_route_field_nxt = serial_route_field_r;
        if (wr_en_in)
        begin
            unique case (wr_sel_in)
                SEL_DATA: port_output_data_nxt = wr_data_in;
                SEL_DIR: port_direction_nxt = wr_data_in;
                SEL_ALT: port_alt_output_enable_nxt = wr_data_in;
                SEL_DRIVE: port_drive_type_nxt = wr_data_in;
                SEL_PULLUP: port_pullup_enable_nxt = wr_data_in;
                SEL_ROUTE: serial_route_field_nxt = wr_data_in[1:0];
                default: port_output_data_nxt = port_output_data_r;
            endcase
        end
    end

    // Direction and alternate enables clear at reset so no pin drives early.
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            port_output_data_r <= DATA_RST;
            port_direction_r <= DIR_RST;
            port_alt_output_enable_r <= ALT_RST;
            port_drive_type_r <= DRIVE_RST;
            port_pullup_enable_r <= PULLUP_RST;
            serial_route_field_r <= ROUTE_RST;
        end
        else
        begin
            port_output_data_r <= port_output_data_nxt;
            port_direction_r <= port_direction_nxt;
            port_alt_output_enable_r <= port_alt_output_enable_nxt;
            port_drive_type_r <= port_drive_type_nxt;
            port_pullup_enable_r <= port_pullup_enable_nxt;
            serial_route_field_r <= serial_route_field_nxt;
        end
    end

    // Two-stage synchroniser; only pin_sync_r is read by logic.
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            pin_meta_r <= SYNC_RST;
            pin_sync_r <= SYNC_RST;
        end
        else
        begin
            pin_meta_r <= pin_in;
            pin_sync_r <= pin_meta_r;
        end
    end

    // The read captures the pin level in the read cycle only; nothing is held
    // between reads, so slow or bouncing inputs must be filtered in software.
    // Output-mode bits read back the latch rather than the pad.
    always_comb
    begin
        read_nxt = read_r;
        if (rd_en_in)
        begin
            read_nxt = (pin_sync_r & ~port_direction_r) | (port_output_data_r & port_direction_r);
        end
    end

    // Routed peripheral inputs; unselected ones idle high so a receiver sees no start bit.
    always_comb
    begin
        periph_in_nxt = PERIPH_IN_IDLE;
        if (serial_route_field_r[ROUTE_UART_BIT])
        begin
            periph_in_nxt[0] = pin_sync_r[BIT_MISO_RX];
        end
        else
        begin
            periph_in_nxt[1] = pin_sync_r[BIT_MISO_RX];
            periph_in_nxt[2] = pin_sync_r[BIT_MOSI_TX];
            periph_in_nxt[3] = pin_sync_r[BIT_SPI_CLK];
            periph_in_nxt[4] = pin_sync_r[BIT_SPI_SS];
        end
        if (serial_route_field_r[ROUTE_SYNC_BIT])
        begin
            periph_in_nxt[5] = pin_sync_r[BIT_SYNC_CLK];
        end
    end

    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            read_r <= READ_RST;
            periph_in_r <= PERIPH_IN_IDLE;
        end
        else
        begin
            read_r <= read_nxt;
            periph_in_r <= periph_in_nxt;
        end
    end

    // Secondary output source per pin, after serial routing.
    always_comb
    begin
        alt_src = periph_out_in;
        if (serial_route_field_r[ROUTE_UART_BIT])
        begin
            alt_src[BIT_MOSI_TX] = uart_b_transmit_in;
        end
        else
        begin
            alt_src[BIT_MISO_RX] = spi_miso_in;
            alt_src[BIT_MOSI_TX] = spi_mosi_in;
            alt_src[BIT_SPI_CLK] = spi_style_clock_in;
        end
        if (serial_route_field_r[ROUTE_SYNC_BIT])
        begin
            alt_src[BIT_SYNC_CLK] = sync_serial_clock_in;
        end
    end

    // Pin drivers; combinational from the latch so a write shows next cycle.
    // Open-drain only enables the driver for a low, letting the pull-up or
    // the board raise the line.
    genvar g;
    generate
        for (g = 0; g < PORT_W; g++)
        begin : g_pin
            assign drive_val[g] = port_alt_output_enable_r[g] ? alt_src[g] : port_output_data_r[g];
            assign pin_out[g] = port_drive_type_r[g] ? 1'b0 : drive_val[g];
            assign pin_oe_out[g] = port_direction_r[g] & (~port_drive_type_r[g] | ~drive_val[g]);
            assign pullup_on_out[g] = port_pullup_enable_r[g] & (~port_direction_r[g] | port_drive_type_r[g]);
        end
    endgenerate

    // Status and peripheral outputs.
    assign port_pin_read_out = read_r;
    assign port_direction_out = port_direction_r;
    assign serial_route_field_out = serial_route_field_r;
    assign uart_b_receive_out = periph_in_r[0];
    assign spi_miso_out = periph_in_r[1];
    assign spi_mosi_out = periph_in_r[2];
    assign spi_style_clock_out = periph_in_r[3];
    assign spi_ss_out = periph_in_r[4];
    assign sync_serial_clock_out = periph_in_r[5];

    // Checks.
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    a_latch_hold: assert property (!(wr_en_in && wr_sel_in == SEL_DATA) |=> $stable(port_output_data_r))
        else $error("Output latch changed without a data write.");
    a_read_sample: assert property (rd_en_in
        |=> ((read_r ^ $past(pin_sync_r)) & ~$past(port_direction_r)) == 8'h00)
        else $error("Read did not capture the live input level.");
    a_write_visible: assert property (wr_en_in && wr_sel_in == SEL_DATA
        && port_direction_r == 8'hFF && port_alt_output_enable_r == 8'h00 && port_drive_type_r == 8'h00
        |=> pin_out == $past(wr_data_in))
        else $error("Written value did not reach the pins next cycle.");
    a_output_drive: assert property (((pin_out ^ port_output_data_r) & port_direction_r
        & ~port_alt_output_enable_r & ~port_drive_type_r) == 8'h00)
        else $error("Output pin not driven from the data latch.");
    a_input_float: assert property ((pin_oe_out & ~port_direction_r) == 8'h00)
        else $error("Input-mode pin is being driven.");
    a_uart_route: assert property (serial_route_field_r[0] && port_direction_r[5]
        && port_alt_output_enable_r[5] && !port_drive_type_r[5] |-> pin_out[5] == uart_b_transmit_in)
        else $error("UART transmit not routed to bit 5.");
    a_open_drain: assert property ((port_drive_type_r & pin_out) == 8'h00
        && (port_drive_type_r & pin_oe_out & drive_val) == 8'h00)
        else $error("Open-drain pin driven high.");
    a_pullup_gate: assert property ((pullup_on_out & port_direction_r & ~port_drive_type_r) == 8'h00)
        else $error("Pull-up on a push-pull output.");
    a_spi_route: assert property (!serial_route_field_r[0] && port_direction_r[4]
        && port_alt_output_enable_r[4] && !port_drive_type_r[4] |-> pin_out[4] == spi_style_clock_in)
        else $error("SPI-style clock not routed to bit 4.");
    a_sync_clock: assert property (serial_route_field_r[1] |=> sync_serial_clock_out == $past(pin_sync_r[2]))
        else $error("Sync clock input not taken from bit 2.");
    a_alt_select: assert property (port_direction_r[0] && !port_drive_type_r[0]
        |-> pin_out[0] == (port_alt_output_enable_r[0] ? periph_out_in[0] : port_output_data_r[0]))
        else $error("Wrong source on bit 0.");
    // Checked one edge later, so the very first edge with unset registers cannot fire it.
    a_reset_clear: assert property (@(posedge clock_in) disable iff (1'b0) !rst_b_in
        |=> port_direction_r == 8'h00 && port_alt_output_enable_r == 8'h00 && pin_oe_out == 8'h00)
        else $error("Direction or alternate enable not clear in reset.");

    c_read: cover property (rd_en_in ##1 read_r != 8'h00);
    c_uart: cover property (serial_route_field_r == 2'h1 && pin_oe_out[5]);
    c_open_drain: cover property (port_drive_type_r[0] && pin_oe_out[0]);
    c_sync: cover property (serial_route_field_r == 2'h3 && pin_oe_out[2]);

endmodule

/* pio_board.sv */
// Board-side model of the eight port pads: device driver, external sources and pull-ups.
// Assumes one clock; a released pad with no board source and no pull-up floats to a level that flips every cycle.
`timescale 1ns/1ns

module pio_board
(
    // Clock and reset.
    input wire logic clock_in,
    input wire logic rst_b_in,
    // Device side of the pads.
    input wire logic [7:0] pin_drive_in,
    input wire logic [7:0] pin_oe_in,
    input wire logic [7:0] pullup_in,
    // Board sources.
    input wire logic [7:0] board_en_in,
    input wire logic [7:0] board_val_in,
    // Resolved pad level.
    output logic [7:0] level_out
);
    logic float_r;

    // A floating pad toggles, so a stale level can never pass for a driven one.
    always_ff @(posedge clock_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            float_r <= 1'b0;
        else
            float_r <= ~float_r;
    end

    // The pad driver wins, then the board source, then the pull-up.
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pin_oe_in[i])
                level_out[i] = pin_drive_in[i];
            else if (board_en_in[i])
                level_out[i] = board_val_in[i];
            else if (pullup_in[i])
                level_out[i] = 1'b1;
            else
                level_out[i] = float_r;
        end
    end
endmodule

/* tb_parallel_io_port_control.sv */
// Self-checking bench for the parallel port control block with a board model on the pins.
// Assumes the design package is compiled first; stimulus moves 1 ns after each rising edge.
`timescale 1ns/1ns

module tb_parallel_io_port_control
    import pio_pkg::*;
    ;
    logic clock_in = 0, rst_b_in = 0, wr_en = 0, rd_en = 0;
    reg_sel_e wr_sel = SEL_DATA;
    logic [7:0] wr_data = 0, periph = 0, bd_en = 0, bd_val = 0, e;
    logic tx = 0, miso = 0, mosi = 0, sclk = 0, sync = 0;
    logic [7:0] rd_q, dir_q, pin_o, oe, pu, level;
    logic [1:0] route_q;
    logic rx_o, miso_o, mosi_o, sclk_o, ss_o, sync_o;
    logic [31:0] seed = 32'h19A8;
    int fails = 0, total_checks = 0, cycles = 0, m_data, m_dir, m_drv, m_pu;
    int exp_q[$];

    parallel_io_port_control dut_u (.clock_in(clock_in), .rst_b_in(rst_b_in), .wr_en_in(wr_en),
        .wr_sel_in(wr_sel), .wr_data_in(wr_data), .rd_en_in(rd_en), .port_pin_read_out(rd_q),
        .port_direction_out(dir_q), .serial_route_field_out(route_q), .pin_in(level), .pin_out(pin_o),
        .pin_oe_out(oe), .pullup_on_out(pu), .periph_out_in(periph), .uart_b_transmit_in(tx),
        .spi_miso_in(miso), .spi_mosi_in(mosi), .spi_style_clock_in(sclk), .sync_serial_clock_in(sync),
        .uart_b_receive_out(rx_o), .spi_miso_out(miso_o), .spi_mosi_out(mosi_o),
        .spi_style_clock_out(sclk_o), .spi_ss_out(ss_o), .sync_serial_clock_out(sync_o));

    pio_board board_u (.clock_in(clock_in), .rst_b_in(rst_b_in), .pin_drive_in(pin_o), .pin_oe_in(oe),
        .pullup_in(pu), .board_en_in(bd_en), .board_val_in(bd_val), .level_out(level));

    // Clock, and a cycle ceiling well above the roughly 750 cycles the run needs.
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            fails++;
            stop_test();
        end
    end

    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction

    task automatic chk(input logic [7:0] x, input logic [7:0] a);
        total_checks++;
        if (a !== x)
        begin
            fails++;
            $display("FAIL t=%0t exp=%h got=%h", $time, x, a);
        end
    endtask

    // One write per call; successive calls make back-to-back strobes and update the model.
    task automatic wr(input reg_sel_e s, input logic [7:0] d);
        @(posedge clock_in);
        #1;
        wr_en = 1;
        wr_sel = s;
        wr_data = d;
        if (s == SEL_DATA) m_data = d;
        if (s == SEL_DIR) m_dir = d;
        if (s == SEL_DRIVE) m_drv = d;
        if (s == SEL_PULLUP) m_pu = d;
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge clock_in);
            #1;
            wr_en = 0;
            rd_en = 0;
        end
    endtask

    // Pin read, then the registered result is compared with the oldest expectation.
    task automatic rd();
        @(posedge clock_in);
        #1;
        rd_en = 1;
        idle(2);
        chk(8'(exp_q.pop_front()), rd_q);
    endtask

    task automatic do_reset();
        rst_b_in = 0;
        idle(8);
        chk(8'h00, dir_q);
        chk(8'h00, oe | pu | {6'h00, route_q});
        chk(8'h3F, {2'b00, rx_o, miso_o, mosi_o, sclk_o, ss_o, sync_o});
        chk(8'h00, rd_q | pin_o);
        {m_data, m_dir, m_drv, m_pu} = '0;
        rst_b_in = 1;
    endtask

    task automatic stop_test();
        if (fails == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Main sequence: latch timing, random port setups, serial routing, reset at the end.
    initial
    begin
        do_reset();
        wr(SEL_DIR, 8'hFF);
        wr(SEL_DATA, 8'hA5);
        idle(1);
        chk(8'hA5, pin_o);
        wr(SEL_DATA, 8'h3C);
        chk(8'hA5, pin_o);
        wr(SEL_PULLUP, 8'hFF);
        chk(8'h3C, pin_o);
        idle(6);
        chk(8'h3C, pin_o);
        repeat (40)
        begin
            wr(SEL_DATA, rnd());
            wr(SEL_DIR, rnd());
            wr(SEL_DRIVE, rnd());
            wr(SEL_PULLUP, rnd());
            idle(1);
            bd_en = ~8'(m_dir);
            bd_val = rnd();
            chk(8'(m_dir), dir_q);
            chk(8'(m_dir & ~(m_drv & m_data)), oe);
            chk(8'(m_dir & m_data & ~m_drv), pin_o & 8'(m_dir));
            chk(8'(m_pu & (~m_dir | m_drv)), pu);
            exp_q.push_back((m_dir & m_data) | (~m_dir & bd_val));
            idle(3);
            rd();
            bd_val = ~bd_val;
            exp_q.push_back((m_dir & m_data) | (~m_dir & bd_val));
            idle(3);
            rd();
        end
        for (int r = 0; r < 4; r++)
        begin
            wr(SEL_ROUTE, 8'(r));
            wr(SEL_DRIVE, 8'h00);
            wr(SEL_ALT, 8'hFF);
            wr(SEL_DIR, 8'hFF);
            periph = rnd();
            {tx, miso, mosi, sclk, sync} = 5'(rnd());
            idle(1);
            chk(8'(r), {6'h00, route_q});
            // Pins that routing leaves alone carry the plain alternate outputs.
            e = periph;
            e[5] = r[0] ? tx : mosi;
            if (!r[0])
            begin
                e[6] = miso;
                e[4] = sclk;
            end
            if (r[1])
                e[2] = sync;
            chk(e, pin_o);
            wr(SEL_DIR, 8'h00);
            bd_en = 8'hFF;
            bd_val = rnd();
            idle(5);
            e = {2'b00, r[0] ? bd_val[6] : 1'b1, r[0] ? 1'b1 : bd_val[6], r[0] ? 1'b1 : bd_val[5],
                 r[0] ? 1'b1 : bd_val[4], r[0] ? 1'b1 : bd_val[3], r[1] ? bd_val[2] : 1'b1};
            chk(e, {2'b00, rx_o, miso_o, mosi_o, sclk_o, ss_o, sync_o});
        end
        wr(SEL_DIR, 8'hFF);
        idle(1);
        do_reset();
        stop_test();
    end
endmodule
